/* design/i2pp_dev.sv */
// target end: serial register port with coefficient and register space
`timescale 1ns/100ps
module i2pp_dev
   import i2pp_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst,
   i2pp_if.dev                          link,
   input  wire logic [47:0]             audio_sample,
   output logic                         upd_valid,
   output logic [15:0]                  upd_addr,
   output logic [31:0]                  upd_data,
   output i2pp_pkg::i2pp_region_e       upd_region,
   output logic [1:0]                   upd_speaker,
   output logic                         coefficient_write_unlock
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_RAH  = 3'b010,
      ST_RAL  = 3'b011,
      ST_WR   = 3'b100,
      ST_RD   = 3'b101,
      ST_IGN  = 3'b110
   } i2pp_st_e;

   // link side, clocked by the rising serial clock
   typedef struct packed {
      i2pp_st_e    st;
      i2pp_st_e    nxt;
      logic [3:0]  cnt;
      logic [6:0]  sh;
      logic        ack;
      logic [15:0] addr;
      logic [31:0] data;
      logic [1:0]  bidx;
      logic [31:0] rdw;
      logic [31:0] dbg;
      logic [15:0] ev_addr;
      logic [31:0] ev_data;
      logic        ev_tgl;
      logic        frz;
      logic        seen;
   } i2pp_lnk_s;

   // user side, clocked by clock
   typedef struct packed {
      logic        ev_s1;
      logic        ev_s2;
      logic        ev_s3;
      logic        unl_s1;
      logic        unl_s2;
      logic        frz_s1;
      logic        frz_s2;
      logic [47:0] smp;
      logic        upd_valid;
      logic [15:0] upd_addr;
      logic [31:0] upd_data;
      i2pp_region_e upd_region;
      logic [1:0]  upd_speaker;
      logic        unlock;
   } i2pp_sys_s;

   i2pp_lnk_s    lq;
   i2pp_lnk_s    ld;
   i2pp_sys_s    sq;
   i2pp_sys_s    sd;
   logic         start_tgl;
   logic         sda_oe_q;
   logic         drive;
   logic [7:0]   byte_in;
   logic [7:0]   tx_byte;
   logic [31:0]  full;
   logic [31:0]  rd_word;
   logic         wr_coef;
   logic         wr_reg;
   i2pp_region_e rg;
   logic [31:0]  coef_mem [COEF_WORDS];
   logic [31:0]  reg_mem  [REG_WORDS];

   // ======================================================
   // start detection
   i2pp_start_det u_det
   (
      .rst       (rst),
      .scl       (link.scl),
      .sda       (link.sda),
      .start_tgl (start_tgl)
   );

   // ======================================================
   // read mux over the three spaces
   always_comb
   begin
      rg = i2pp_region(lq.addr);
      case (rg)
         RG_ARRAY,
         RG_PRE:  rd_word = coef_mem[lq.addr[10:0]];
         RG_REG:  rd_word = (lq.addr == DBG_REG) ? lq.dbg
                                                 : reg_mem[lq.addr[5:0]];
         RG_SMP:  rd_word = lq.addr[0] ? {16'h0000, sq.smp[47:32]}
                                       : sq.smp[31:0];
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // ======================================================
   // byte engine: eight data clocks, then one acknowledge clock
   always_comb
   begin
      ld      = lq;
      byte_in = {lq.sh, link.sda};
      full    = {byte_in, lq.data[23:0]};
      wr_coef = 1'b0;
      wr_reg  = 1'b0;
      if (start_tgl != lq.seen)
      begin
         // first rising edge after a start carries address bit 6
         ld.seen = start_tgl;
         ld.st   = ST_ADDR;
         ld.cnt  = 4'h1;
         ld.sh   = {lq.sh[5:0], link.sda};
         ld.ack  = 1'b0;
      end
      else if (lq.st != ST_IDLE && lq.st != ST_IGN)
      begin
         if (lq.cnt == ACK_CNT)
         begin
            ld.cnt = 4'h0;
            ld.ack = 1'b0;
            ld.st  = lq.nxt;
            if (lq.st == ST_RD)
            begin
               // controller nack or fourth byte ends the read
               if (link.sda || lq.bidx == LAST_BYTE)
                  ld.st = ST_IGN;
               else
                  ld.bidx = lq.bidx + 2'h1;
            end
            if (ld.st == ST_IGN)
               ld.frz = 1'b0;
         end
         else
         begin
            ld.cnt = lq.cnt + 4'h1;
            ld.sh  = {lq.sh[5:0], link.sda};
            if (lq.cnt == LAST_BIT)
            begin
               ld.ack = 1'b1;
               case (lq.st)
                  ST_ADDR:
                  begin
                     if (byte_in[7:1] == DEV_ADDR)
                     begin
                        ld.bidx = 2'h0;
                        ld.rdw  = rd_word;
                        ld.nxt  = byte_in[0] ? ST_RD : ST_RAH;
                     end
                     else
                     begin
                        ld.ack = 1'b0;
                        ld.nxt = ST_IGN;
                     end
                  end
                  ST_RAH:
                  begin
                     ld.addr[15:8] = byte_in;
                     ld.nxt        = ST_RAL;
                  end
                  ST_RAL:
                  begin
                     ld.addr[7:0] = byte_in;
                     ld.nxt       = ST_WR;
                     ld.bidx      = 2'h0;
                     // hold the sample snapshot still for a later read
                     ld.frz = (i2pp_region({lq.addr[15:8], byte_in})
                               == RG_SMP);
                  end
                  ST_WR:
                  begin
                     ld.data[lq.bidx*8 +: 8] = byte_in;
                     ld.bidx = lq.bidx + 2'h1;
                     ld.nxt  = ST_WR;
                     if (lq.bidx == LAST_BYTE)
                     begin
                        ld.nxt = ST_IGN;
                        // coefficient space locked outside debug mode
                        wr_coef = (rg == RG_ARRAY || rg == RG_PRE) &&
                                  lq.dbg[UNLOCK_BIT];
                        wr_reg  = (rg == RG_REG) && (lq.addr != DBG_REG);
                        if (rg == RG_REG && lq.addr == DBG_REG)
                           ld.dbg = full;
                        if (wr_coef || rg == RG_REG)
                        begin
                           ld.ev_addr = lq.addr;
                           ld.ev_data = full;
                           ld.ev_tgl  = ~lq.ev_tgl;
                        end
                     end
                  end
                  ST_RD:   ld.ack = 1'b0;  // controller answers here
                  default: ld.nxt = ST_IGN;
               endcase
            end
         end
      end
   end

   // reset is not synchronised to scl; scl idles high at its release
   always_ff @(posedge link.scl or posedge rst)
   begin
      if (rst)
      begin
         lq     <= '0;
         lq.dbg <= DBG_REG_RST;
      end
      else
         lq <= ld;
   end

   // memories carry no reset, software loads them
   always_ff @(posedge link.scl)
   begin
      if (wr_coef)
         coef_mem[lq.addr[10:0]] <= full;
      if (wr_reg)
         reg_mem[lq.addr[5:0]] <= full;
   end

   // ======================================================
   // data drive on the falling edge keeps sda still while scl is high
   always_comb
   begin
      tx_byte = lq.rdw[lq.bidx*8 +: 8];
      if (lq.cnt == ACK_CNT)
         drive = lq.ack;
      else if (lq.st == ST_RD)
         drive = ~tx_byte[3'h7 - lq.cnt[2:0]];
      else
         drive = 1'b0;
   end

   always_ff @(negedge link.scl or posedge rst)
   begin
      if (rst)
         sda_oe_q <= 1'b0;
      else
         sda_oe_q <= drive;
   end

   assign link.dev_sda_o  = 1'b0;
   assign link.dev_sda_oe = sda_oe_q;

   // ======================================================
   // user side: toggle crossing for writes, two-stage levels
   always_comb
   begin
      sd           = sq;
      sd.ev_s1     = lq.ev_tgl;
      sd.ev_s2     = sq.ev_s1;
      sd.ev_s3     = sq.ev_s2;
      sd.unl_s1    = lq.dbg[UNLOCK_BIT];
      sd.unl_s2    = sq.unl_s1;
      sd.unlock    = sq.unl_s2;
      sd.frz_s1    = lq.frz;
      sd.frz_s2    = sq.frz_s1;
      sd.upd_valid = 1'b0;
      if (!sq.frz_s2)
         sd.smp = audio_sample;
      // event words stay put for a whole byte time after the toggle
      if (sq.ev_s2 != sq.ev_s3)
      begin
         sd.upd_valid   = 1'b1;
         sd.upd_addr    = lq.ev_addr;
         sd.upd_data    = lq.ev_data;
         sd.upd_region  = i2pp_region(lq.ev_addr);
         sd.upd_speaker = i2pp_speaker(lq.ev_addr);
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sq            <= '0;
         sq.upd_region <= RG_NONE;
      end
      else
         sq <= sd;
   end

   assign upd_valid                = sq.upd_valid;
   assign upd_addr                 = sq.upd_addr;
   assign upd_data                 = sq.upd_data;
   assign upd_region               = sq.upd_region;
   assign upd_speaker              = sq.upd_speaker;
   assign coefficient_write_unlock = sq.unlock;
endmodule

/* design/i2pp_host.sv */
// controller end: runs seven-byte writes and repeated-start reads
`timescale 1ns/100ps
module i2pp_host
   import i2pp_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   i2pp_if.host             link,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic        cmd_read,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [31:0] cmd_wdata,
   output logic             rsp_valid,
   output logic [31:0]      rsp_rdata,
   output logic             rsp_nack
);
   typedef enum logic [0:0] {
      HS_IDLE = 1'b0,
      HS_RUN  = 1'b1
   } i2pp_hst_e;

   typedef struct packed {
      i2pp_hst_e   st;
      logic [3:0]  idx;
      logic [3:0]  bitn;
      logic [1:0]  qtr;
      logic [5:0]  cnt;
      logic [7:0]  sh;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
      logic        nack;
      logic        scl_oe;
      logic        sda_oe;
      logic        sda_s1;
      logic        sda_s2;
      logic        cmd_ready;
      logic        rsp_valid;
      logic [31:0] rsp_rdata;
   } i2pp_host_s;

   localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);

   i2pp_host_s q;
   i2pp_host_s d;
   i2pp_tok_e  kind;
   logic [7:0] tbyte;
   logic [3:0] last_idx;
   logic [1:0] rb;

   // ======================================================
   // token list: write S A H L D0..D3 P, read S A H L Sr A' R0..R3 P
   function automatic logic [9:0] tok(input logic [3:0] i, input logic r,
                                      input logic [15:0] a,
                                      input logic [31:0] w);
      if (i == 4'h0 || (r && i == 4'h4))
         return {TK_START, 8'h00};
      else if (i == 4'h1)
         return {TK_TX, DEV_ADDR, 1'b0};
      else if (i == 4'h2)
         return {TK_TX, a[15:8]};
      else if (i == 4'h3)
         return {TK_TX, a[7:0]};
      else if (r && i == 4'h5)
         return {TK_TX, DEV_ADDR, 1'b1};
      else if (r && i < 4'ha)
         return {TK_RX, 8'h00};
      else if (!r && i < 4'h8)
         return {TK_TX, w[(i - 4'h4)*8 +: 8]};
      else
         return {TK_STOP, 8'h00};
   endfunction

   // ======================================================
   // quarter-bit sequencer, scl low for two quarters, high for two
   always_comb
   begin
      d           = q;
      d.sda_s1    = link.sda;
      d.sda_s2    = q.sda_s1;
      d.rsp_valid = 1'b0;
      last_idx    = q.rd ? 4'ha : 4'h8;
      rb          = 2'(q.idx - 4'h6);
      {kind, tbyte} = tok(q.idx, q.rd, q.addr, q.wdata);
      if (q.st == HS_IDLE)
      begin
         d.scl_oe = 1'b0;
         d.sda_oe = 1'b0;
         if (cmd_valid && q.cmd_ready)
         begin
            d.st        = HS_RUN;
            d.cmd_ready = 1'b0;
            d.rd        = cmd_read;
            d.addr      = cmd_addr;
            d.wdata     = cmd_wdata;
            d.nack      = 1'b0;
            d.idx       = 4'h0;
            d.bitn      = 4'h0;
            d.qtr       = 2'h3;
            d.cnt       = 6'h00;
         end
      end
      else if (q.cnt != 6'h00)
         d.cnt = q.cnt - 6'h01;
      else
      begin
         d.cnt = QTR_LAST;
         d.qtr = q.qtr + 2'h1;
         if (q.qtr == 2'h3 && !(q.idx == 4'h0 && q.bitn == 4'h0 &&
                                q.cmd_ready == 1'b0 && q.sh == 8'h00 &&
                                q.scl_oe == 1'b0 && q.sda_oe == 1'b0))
         begin
            // end of the high half: sample, then advance
            d.bitn = q.bitn + 4'h1;
            if (kind == TK_RX && q.bitn < ACK_CNT)
               d.sh = {q.sh[6:0], q.sda_s2};
            if (kind == TK_RX && q.bitn == ACK_CNT)
               d.rsp_rdata[rb*8 +: 8] = q.sh;
            if (kind == TK_START || kind == TK_STOP ||
                q.bitn == ACK_CNT)
            begin
               d.bitn = 4'h0;
               d.idx  = q.idx + 4'h1;
               d.sh   = 8'h01;
               if (kind == TK_TX && q.sda_s2)
               begin
                  d.nack = 1'b1;     // target refused, finish with stop
                  d.idx  = last_idx;
               end
               if (kind == TK_STOP)
               begin
                  d.st        = HS_IDLE;
                  d.cmd_ready = 1'b1;
                  d.rsp_valid = 1'b1;
                  d.sh        = 8'h00;
                  d.idx       = 4'h0;
               end
            end
         end
      end
      // line drive for the phase being entered
      if (d.st == HS_RUN)
      begin
         {kind, tbyte} = tok(d.idx, d.rd, d.addr, d.wdata);
         d.scl_oe = (d.qtr < 2'h2);
         if (d.qtr == 2'h1)
         begin
            case (kind)
               TK_START: d.sda_oe = 1'b0;
               TK_STOP:  d.sda_oe = 1'b1;
               TK_TX:    d.sda_oe = (d.bitn < ACK_CNT) &&
                                    !tbyte[3'h7 - d.bitn[2:0]];
               TK_RX:    d.sda_oe = (d.bitn == ACK_CNT) &&
                                    (d.idx != 4'h9);
               default:  d.sda_oe = 1'b0;
            endcase
         end
         else if (d.qtr == 2'h3 && kind == TK_START)
            d.sda_oe = 1'b1;
         else if (d.qtr == 2'h3 && kind == TK_STOP)
            d.sda_oe = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         q           <= '0;
         q.cmd_ready <= 1'b1;
      end
      else
         q <= d;
   end

   assign link.host_scl_o  = 1'b0;
   assign link.host_sda_o  = 1'b0;
   assign link.host_scl_oe = q.scl_oe;
   assign link.host_sda_oe = q.sda_oe;
   assign cmd_ready        = q.cmd_ready;
   assign rsp_valid        = q.rsp_valid;
   assign rsp_rdata        = q.rsp_rdata;
   assign rsp_nack         = q.nack;
endmodule

/* design/i2pp_if.sv */
// open-drain two-wire link between controller and register port
`timescale 1ns/100ps
interface i2pp_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // pull-ups: a line is low only while some party drives a low
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (input scl, input sda, output host_scl_o,
                 output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

/* design/i2pp_pkg.sv */
// shared constants, types and decoders of the paged register port
package i2pp_pkg;

   // ======================================================
   // link addressing and timing
   localparam logic [6:0] DEV_ADDR        = 7'h30;  // 0110000
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned SCL_MAX_KHZ    = 400;
   localparam int unsigned SCL_PERIOD_NS  = 1000000 / SCL_MAX_KHZ;
   // quarter of the shortest legal bit, rounded up so 400 kHz never passes
   localparam int unsigned QTR_CYC        =
      (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam logic [3:0] LAST_BIT        = 4'h7;
   localparam logic [3:0] ACK_CNT         = 4'h8;
   localparam logic [1:0] LAST_BYTE       = 2'h3;

   // ======================================================
   // address map
   localparam logic [15:0] PRE_BASE       = 16'h0400;
   localparam logic [15:0] PRE_END        = 16'h047f;
   localparam logic [15:0] REG_BASE       = 16'h0500;
   localparam logic [15:0] REG_END        = 16'h053f;
   localparam logic [15:0] DBG_REG        = 16'h0504;
   localparam logic [15:0] SMP_LO         = 16'h0600;
   localparam logic [15:0] SMP_HI         = 16'h0601;
   localparam int unsigned COEF_WORDS     = 1152;
   localparam int unsigned REG_WORDS      = 64;
   localparam int unsigned UNLOCK_BIT     = 7;
   localparam logic [31:0] DBG_REG_RST    = 32'h0000_00ff;
   localparam int unsigned TAP_UPPER_LSB  = 16;
   localparam int unsigned TAP_BITS       = 16;
   localparam int unsigned SMP_BITS       = 48;

   typedef enum logic [2:0] {
      RG_ARRAY = 3'b000,
      RG_PRE   = 3'b001,
      RG_REG   = 3'b010,
      RG_SMP   = 3'b011,
      RG_NONE  = 3'b100
   } i2pp_region_e;

   // host sequencer token kinds
   typedef enum logic [1:0] {
      TK_START = 2'b00,
      TK_TX    = 2'b01,
      TK_RX    = 2'b10,
      TK_STOP  = 2'b11
   } i2pp_tok_e;

   // ======================================================
   // decoders
   function automatic i2pp_region_e i2pp_region(input logic [15:0] a);
      if (a < PRE_BASE)
         return RG_ARRAY;
      else if (a <= PRE_END)
         return RG_PRE;
      else if (a >= REG_BASE && a <= REG_END)
         return RG_REG;
      else if (a == SMP_LO || a == SMP_HI)
         return RG_SMP;
      else
         return RG_NONE;
   endfunction

   // speaker output number minus one; lowest block feeds output 4
   function automatic logic [1:0] i2pp_speaker(input logic [15:0] a);
      return ~a[9:8];
   endfunction

endpackage

/* design/i2pp_start_det.sv */
// start condition detector clocked by the falling data line
`timescale 1ns/100ps
module i2pp_start_det
(
   input  wire logic rst,
   input  wire logic scl,
   input  wire logic sda,
   output logic      start_tgl
);
   typedef struct packed {
      logic tgl;
   } i2pp_det_s;

   i2pp_det_s q;
   i2pp_det_s d;

   // ======================================================
   // toggle per start; scl low edge follows by at least the hold time
   always_comb
   begin
      d = q;
      if (scl)
         d.tgl = ~q.tgl;
   end

   always_ff @(negedge sda or posedge rst)
   begin
      if (rst)
         q <= '0;
      else
         q <= d;
   end

   assign start_tgl = q.tgl;
endmodule

/* verif/i2pp_monitor.sv */
// link checker between controller end and register port end
`timescale 1ns/100ps
module i2pp_monitor
   import i2pp_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic dev_sda_oe,
   input  wire logic scl,
   input  wire logic sda
);
   // ==========================================================
   // bit position inside a frame
   localparam int MIN_PER = SCL_PERIOD_NS / CLK_PERIOD_NS;
   logic [6:0] bit_q;
   logic [8:0] per_q;
   logic       rw_q;
   logic       act_q;

   // count rising serial clocks; a start restarts the count
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bit_q <= '0;
         per_q <= '1;   // saturated: no earlier edge to measure from
         rw_q  <= 1'b0;
         act_q <= 1'b0;
      end
      else
      begin
         per_q <= $rose(scl) ? '0 : per_q + 9'(per_q != '1);
         if (scl && $fell(sda))
            bit_q <= '0;
         else if ($rose(scl))
            bit_q <= bit_q + 7'h01;
         if (scl && ($fell(sda) || $rose(sda)))
            act_q <= $fell(sda);
         if ($rose(scl) && act_q && bit_q == 7'h07)
            rw_q <= sda;
      end
   end

   // ==========================================================
   // link properties
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_bit;
      $rose(scl) ##0 act_q;
   endsequence
   sequence s_stop;
      scl && $rose(sda);
   endsequence

   AST_SCL_PERIOD: assert property (
      $rose(scl) |-> per_q >= MIN_PER - 1)
      else $error("serial clock period too short");
   AST_DEV_HOLD: assert property (
      scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device data moved while clock high");
   AST_ADDR_BITS: assert property (
      s_bit ##0 (bit_q < 7'h07) |-> sda == DEV_ADDR[3'h6 - bit_q[2:0]])
      else $error("target address bit wrong");
   AST_ADDR_ACK: assert property (
      s_bit ##0 (bit_q == 7'h08) |-> !sda)
      else $error("address not acknowledged");
   AST_REGADDR_ACK: assert property (
      s_bit ##0 (!rw_q && (bit_q == 7'h11 || bit_q == 7'h1a)) |-> !sda)
      else $error("register address byte not acknowledged");
   AST_DATA_ACK: assert property (
      s_bit ##0 (!rw_q && bit_q inside {7'h23, 7'h2c, 7'h35, 7'h3e})
      |-> !sda)
      else $error("write data byte not acknowledged");
   AST_READ_NACK: assert property (
      s_bit ##0 (rw_q && bit_q == 7'h2c) |-> sda)
      else $error("last read byte not left high");
   AST_WRITE_LEN: assert property (
      s_stop |-> rw_q || bit_q == 7'h40)
      else $error("write frame length wrong");
   AST_READ_LEN: assert property (
      s_stop |-> !rw_q || bit_q == 7'h2e)
      else $error("read frame length wrong");
endmodule

/* verif/test_i2pp_paged_register_port.sv */
// self-checking bench joining controller end and register port end
`timescale 1ns/100ps
module test_i2pp_paged_register_port;
   import i2pp_pkg::*;
   logic         clock = 1'b0;
   logic         rst = 1'b0;
   logic         cmd_valid = 1'b0;
   logic         cmd_read = 1'b0;
   logic [15:0]  cmd_addr = '0;
   logic [31:0]  cmd_wdata = '0;
   logic [47:0]  audio_sample = 48'h0a1b_2c3d_4e5f;
   logic         cmd_ready, rsp_valid, rsp_nack, upd_valid, unlock;
   logic [31:0]  rsp_rdata, upd_data;
   logic [15:0]  upd_addr;
   i2pp_region_e upd_region;
   logic [1:0]   upd_speaker;
   logic [63:0]  sh = '0;
   int           bits = 0, upd_cnt = 0, errors = 0, cmp_count = 0;

   // ==========================================================
   // both ends on one link
   i2pp_if i2pp_if_inst();
   i2pp_dev i2pp_dev_inst (.clock(clock), .rst(rst), .link(i2pp_if_inst),
      .audio_sample(audio_sample), .upd_valid(upd_valid),
      .upd_addr(upd_addr), .upd_data(upd_data), .upd_region(upd_region),
      .upd_speaker(upd_speaker), .coefficient_write_unlock(unlock));
   i2pp_host i2pp_host_inst (.clock(clock), .rst(rst), .link(i2pp_if_inst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
   i2pp_monitor i2pp_monitor_inst (.clock(clock), .rst(rst),
      .dev_sda_oe(i2pp_if_inst.dev_sda_oe), .scl(i2pp_if_inst.scl),
      .sda(i2pp_if_inst.sda));

   always #5 clock = ~clock;
   // wire sniffer: bits at rising serial clock since the last start
   always @(negedge i2pp_if_inst.sda)
      if (i2pp_if_inst.scl === 1'b1)
      begin
         bits = 0;
         sh = '0;
      end
   always @(posedge i2pp_if_inst.scl)
   begin
      sh = {sh[62:0], i2pp_if_inst.sda};
      bits++;
   end
   // off-edge sampling of the commit pulse avoids a race with its flop
   always @(negedge clock)
      if (upd_valid === 1'b1)
         upd_cnt++;

   // ==========================================================
   // checking and transfer tasks
   task automatic check(input string nm, input logic [63:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one command end to end; d is the data sent or expected back
   task automatic xfer(input logic rd, input logic [15:0] a,
                       input logic [31:0] d);
      logic [63:0] exp;
      int          n;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_read <= rd;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clock);
      cmd_valid <= 1'b0;
      for (n = 0; n < 30000 && rsp_valid !== 1'b1; n++)
      begin
         @(posedge clock);
         #1;
      end
      exp = rd ? {18'h0, 8'h61, 1'b0, d[7:0], 1'b0, d[15:8], 1'b0,
                  d[23:16], 1'b0, d[31:24], 2'b10}
               : {8'h60, 1'b0, a[15:8], 1'b0, a[7:0], 1'b0, d[7:0], 1'b0,
                  d[15:8], 1'b0, d[23:16], 1'b0, d[31:24], 2'b00};
      if (n == 30000)
      begin
         check("rsp_valid", 64'h0, 64'h1);
         final_report();
      end
      else
      begin
         check("wire bits", rd ? {18'h0, sh[45:0]} : sh, exp);
         check("bit count", 64'(bits), rd ? 64'h2e : 64'h40);
         check("rsp_nack", 64'(rsp_nack), 64'h0);
         check("cmd_ready", 64'(cmd_ready), 64'h1);
         if (rd)
            check("rsp_rdata", 64'(rsp_rdata), 64'(d));
      end
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      // a real edge on reset: a declaration value raises no event
      rst <= 1'b1;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
      check("unlock", 64'(unlock), 64'h1);
      xfer(1'b0, 16'h0100, 32'ha5c3_1e87);
      check("upd count", 64'(upd_cnt), 64'h1);
      check("upd_addr", 64'(upd_addr), 64'h0100);
      check("upd_data", 64'(upd_data), 64'ha5c3_1e87);
      check("upd_region", 64'(upd_region), 64'(RG_ARRAY));
      check("upd_speaker", 64'(upd_speaker), 64'h2);
      xfer(1'b0, DBG_REG, 32'h0000_007f);
      repeat (4) @(posedge clock);
      #1;
      check("unlock", 64'(unlock), 64'h0);
      xfer(1'b0, 16'h0101, 32'h1234_5678);
      check("upd count", 64'(upd_cnt), 64'h2);
      xfer(1'b1, DBG_REG, 32'h0000_007f);
      // word stored while unlocked must survive the locked write next door
      xfer(1'b1, 16'h0100, 32'ha5c3_1e87);
      check("upd count", 64'(upd_cnt), 64'h2);
      final_report();
   end
endmodule
